// >>> nbx_defs.svh
// Purpose: constants for the branch and miscellaneous execution block
// Assumes: 16-bit instruction words, 10-bit program addresses
// Notes: opcode patterns are compared against the top bits of the word
`ifndef NBX_DEFS_SVH
`define NBX_DEFS_SVH

`define NBX_PC_W        10
`define NBX_PC_TOP      10'h3FF
`define NBX_PC_RESET    10'h000
`define NBX_STACK_DEPTH 4
`define NBX_PREDIV_W    15
`define NBX_PREDIV_CLR  5

// top four bits select bit branch, jump and call; conditional branches use the top six
`define NBX_OP_BIT_BR     4'h8
`define NBX_OP_NONZERO    6'h24
`define NBX_OP_NO_CARRY   6'h25
`define NBX_OP_ZERO       6'h26
`define NBX_OP_CARRY      6'h27
`define NBX_OP_JUMP       4'hA
`define NBX_OP_CALL       4'hB
`define NBX_OP_RTS        16'hC000
`define NBX_OP_DEC_ADJ    16'h5600
`define NBX_OP_DEC_ADJ_WR 8'h57
`define NBX_OP_ARITH_STS  8'h4A
`define NBX_OP_MSB        8'h4B
`define NBX_OP_PRESC_STS  8'h4C
// miscellaneous group: top seven bits, nine operand bits; the timer load from memory uses the top eight bits
`define NBX_OP_DEBOUNCE   7'h68
`define NBX_OP_TMR_MEM    8'h69
`define NBX_OP_TMR_IMM    7'h6A
`define NBX_OP_FSET       7'h6B
`define NBX_OP_FCLR       7'h6C
`define NBX_OP_FSET2      7'h6D
`define NBX_OP_FCLR2      7'h6E
`define NBX_OP_PULSE      7'h6F

`define NBX_ADJ_ADD       4'hA
`define NBX_ADJ_MAX_C     4'h9
`define NBX_ADJ_MIN_NC    4'h6

`define NBX_TAP_9       4'h9
`define NBX_TAP_3       4'h3
`define NBX_TAP_15      4'hF
`define NBX_TAP_5       4'h5
`define NBX_TAP_7       4'h7
`define NBX_TAP_11      4'hB
`define NBX_TAP_13      4'hD
`define NBX_TAP_10      4'hA
`define NBX_TAP_8       4'h8
`define NBX_TAP_6       4'h6

`endif

// >>> nbx_pkg.sv
// Purpose: shared types for the branch and miscellaneous execution block
// Assumes: constants come from nbx_defs.svh
// Notes: none
`include "nbx_defs.svh"
package nbx_pkg;

	typedef logic [`NBX_PC_W-1:0] nbx_addr_t;

	typedef enum logic [1:0]
	{
		NBX_PC_INC  = 2'b00,
		NBX_PC_LOAD = 2'b01,
		NBX_PC_RET  = 2'b10
	} nbx_pc_sel_t;

	// state the rest of the core reports to this block
	typedef struct packed
	{
		logic [3:0] accumulator;
		logic       carry_flag;
		logic       zero_flag;
		logic       start_condition_two;
		logic       start_condition_prescaler;
		logic       prescaler_stage_fifteen;
		logic [3:0] ram_data;
	} nbx_core_state_t;

	// write-back toward accumulator and ram
	typedef struct packed
	{
		logic       acc_we;
		logic       ram_we;
		logic [3:0] data;
	} nbx_wb_t;

	// one-cycle pulses toward the timer and wake logic
	typedef struct packed
	{
		logic       port_wake_clr;
		logic       prescaler_wake_clr;
		logic       timer_wake_clr;
		logic       timer_stop;
		logic       prescaler_tail_clr;
		logic       timer_start;
		logic [5:0] timer_preset;
	} nbx_pulse_t;

endpackage

// >>> nbx_ret_stack.sv
// Purpose: return address stack for subroutine call and return
// Assumes: depth is a power of two, overflow wraps silently
// Notes: a push and a pop never arrive together
`timescale 1ns/1ns
`include "nbx_defs.svh"
module nbx_ret_stack
#(
	parameter int DEPTH = `NBX_STACK_DEPTH
)
(
	input  wire logic               ref_clk,
	input  wire logic               reset,
	input  wire logic               push,
	input  wire logic               pop,
	input  wire nbx_pkg::nbx_addr_t push_addr,
	output nbx_pkg::nbx_addr_t      top_addr
);
	import nbx_pkg::*;

	localparam int PW = $clog2(DEPTH);

	nbx_addr_t        mem_r [DEPTH];
	logic [PW-1:0]    ptr_r;

	// entry below the pointer is the newest one
	assign top_addr = mem_r[ptr_r - PW'(1)];

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			ptr_r <= '0;
		else if (push)
			ptr_r <= ptr_r + PW'(1);
		else if (pop)
			ptr_r <= ptr_r - PW'(1);
	end

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : g_entry
			always_ff @(posedge ref_clk or posedge reset)
			begin
				if (reset)
					mem_r[i] <= `NBX_PC_RESET;
				else if (push && ptr_r == PW'(i))
					mem_r[i] <= push_addr;
			end
		end
	endgenerate
endmodule // nbx_ret_stack

// >>> nbx_das.sv
// Purpose: decimal adjust of the accumulator after a subtraction
// Assumes: accumulator holds the result of a subtract instruction
// Notes: carry is never changed here
`timescale 1ns/1ns
`include "nbx_defs.svh"
module nbx_sub_adjust
(
	input  wire logic [3:0] acc_in,
	input  wire logic       carry_in,
	output logic [3:0]      acc_out
);
	// cases outside both table rows are left as they are
	always_comb
	begin
		acc_out = acc_in;
		if (!carry_in && acc_in >= `NBX_ADJ_MIN_NC)
			acc_out = acc_in + `NBX_ADJ_ADD;
		else if (carry_in && acc_in <= `NBX_ADJ_MAX_C)
			acc_out = acc_in;
	end
endmodule // nbx_sub_adjust

// >>> nbx_branch_misc_exec.sv
// Purpose: executes decimal adjust, branches, call/return, misc control
//          and status reads of a 4-bit core
// Assumes: one instruction word presented per cycle with instr_valid
// Notes: write-back and pulses are registered, one cycle after issue
`timescale 1ns/1ns
`include "nbx_defs.svh"
module nbx_branch_misc_exec
(
	input  wire logic                     ref_clk,
	input  wire logic                     reset,
	input  wire logic                     instr_valid,
	input  wire logic [15:0]              instr_word,
	input  wire nbx_pkg::nbx_core_state_t core_state,
	output nbx_pkg::nbx_addr_t            program_counter,
	output nbx_pkg::nbx_wb_t              write_back,
	output logic                          carry_we,
	output logic                          carry_value,
	output nbx_pkg::nbx_pulse_t           pulses,
	output logic [3:0]                    timer_clock_tap,
	output logic [3:0]                    debounce_clock_tap,
	output logic                          backup_mode_flag,
	output logic                          segments_blanked,
	output logic                          timer_reload_en
);
	import nbx_pkg::*;

	nbx_addr_t   pc_r;
	nbx_addr_t   pc_nxt;
	nbx_addr_t   stack_top;
	nbx_pc_sel_t pc_sel;
	logic        push;
	logic        pop;
	logic [3:0]  acc;
	logic [3:0]  adj_res;
	logic [8:0]  opnd;
	logic [6:0]  op7;
	logic [5:0]  op6;
	logic        take;
	logic        is_adj;
	logic        is_adj_wr;
	logic        is_misc;

	nbx_wb_t     wb_nxt;
	nbx_pulse_t  pulse_nxt;
	logic        cwe_nxt;
	logic        cval_nxt;

	assign acc     = core_state.accumulator;
	assign opnd    = instr_word[8:0];
	assign op7     = instr_word[15:9];
	assign op6     = instr_word[15:10];
	assign is_adj    = instr_word == `NBX_OP_DEC_ADJ;
	assign is_adj_wr = instr_word[15:8] == `NBX_OP_DEC_ADJ_WR;

	nbx_sub_adjust i_nbx_sub_adjust
	(
		.acc_in   (acc),
		.carry_in (core_state.carry_flag),
		.acc_out  (adj_res)
	);

	nbx_ret_stack i_nbx_ret_stack
	(
		.ref_clk   (ref_clk),
		.reset     (reset),
		.push      (push),
		.pop       (pop),
		.push_addr (pc_r + 10'h001),
		.top_addr  (stack_top)
	);

	// branch decision
	always_comb
	begin
		take = 1'b0;
		push = 1'b0;
		pop  = 1'b0;
		if (instr_valid)
		begin
			if (instr_word[15:12] == `NBX_OP_BIT_BR)
				take = acc[instr_word[11:10]];
			else if (op6 == `NBX_OP_NONZERO)
				take = acc != 4'h0;
			else if (op6 == `NBX_OP_ZERO)
				take = acc == 4'h0;
			else if (op6 == `NBX_OP_NO_CARRY)
				take = !core_state.carry_flag;
			else if (op6 == `NBX_OP_CARRY)
				take = core_state.carry_flag;
			else if (instr_word[15:12] == `NBX_OP_JUMP)
				take = 1'b1;
			else if (instr_word[15:12] == `NBX_OP_CALL)
			begin
				take = 1'b1;
				push = 1'b1;
			end
			else if (instr_word == `NBX_OP_RTS)
				pop = 1'b1;
		end
	end

	always_comb
	begin
		if (pop)
			pc_sel = NBX_PC_RET;
		else if (take)
			pc_sel = NBX_PC_LOAD;
		else
			pc_sel = NBX_PC_INC;
	end

	always_comb
	begin
		unique case (pc_sel)
			NBX_PC_LOAD: pc_nxt = instr_word[9:0];
			NBX_PC_RET:  pc_nxt = stack_top;
			NBX_PC_INC:  pc_nxt = pc_r + 10'h001;
			default:     pc_nxt = pc_r + 10'h001;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			pc_r <= `NBX_PC_RESET;
		else if (instr_valid)
			pc_r <= pc_nxt;
	end

	assign program_counter = pc_r;

	// data write-back for adjust and status reads
	always_comb
	begin
		wb_nxt = '0;
		if (instr_valid)
		begin
			if (is_adj || is_adj_wr)
			begin
				wb_nxt.acc_we = 1'b1;
				wb_nxt.ram_we = is_adj_wr;
				wb_nxt.data   = adj_res;
			end
			else if (instr_word[15:8] == `NBX_OP_ARITH_STS)
			begin
				wb_nxt.acc_we = 1'b1;
				wb_nxt.ram_we = 1'b1;
				wb_nxt.data   = {core_state.carry_flag,
					core_state.zero_flag, 2'b00};
			end
			else if (instr_word[15:8] == `NBX_OP_MSB)
			begin
				wb_nxt.acc_we = 1'b1;
				wb_nxt.ram_we = 1'b1;
				wb_nxt.data   = {1'b0, core_state.start_condition_two,
					1'b0, backup_mode_flag};
			end
			else if (instr_word[15:8] == `NBX_OP_PRESC_STS)
			begin
				wb_nxt.acc_we = 1'b1;
				wb_nxt.ram_we = 1'b1;
				wb_nxt.data   = {core_state.start_condition_prescaler,
					core_state.prescaler_stage_fifteen,
					2'b00};
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			write_back <= '0;
		else
			write_back <= wb_nxt;
	end

	// carry changes from flag set and clear
	always_comb
	begin
		cwe_nxt  = 1'b0;
		cval_nxt = 1'b0;
		if (instr_valid && opnd[0])
		begin
			if (op7 == `NBX_OP_FSET)
			begin
				cwe_nxt  = 1'b1;
				cval_nxt = 1'b1;
			end
			else if (op7 == `NBX_OP_FCLR)
				cwe_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			carry_we    <= 1'b0;
			carry_value <= 1'b0;
		end
		else
		begin
			carry_we    <= cwe_nxt;
			carry_value <= cval_nxt;
		end
	end

	// one-shot pulses and timer loads
	assign is_misc = instr_valid;

	always_comb
	begin
		pulse_nxt = '0;
		if (is_misc && op7 == `NBX_OP_PULSE)
		begin
			pulse_nxt.port_wake_clr      = opnd[0];
			pulse_nxt.prescaler_wake_clr = opnd[3];
			pulse_nxt.timer_wake_clr     = opnd[4];
			pulse_nxt.timer_stop         = opnd[4];
			// software also sets bit three; relied on, not forced
			pulse_nxt.prescaler_tail_clr = opnd[8];
		end
		else if (is_misc && instr_word[15:8] == `NBX_OP_TMR_MEM)
		begin
			pulse_nxt.timer_start  = 1'b1;
			pulse_nxt.timer_preset = {acc[1:0],
				core_state.ram_data};
		end
		else if (is_misc && op7 == `NBX_OP_TMR_IMM)
		begin
			pulse_nxt.timer_start  = 1'b1;
			pulse_nxt.timer_preset = opnd[5:0];
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			pulses <= '0;
		else
			pulses <= pulse_nxt;
	end

	// timer clock select; unlisted codes keep the previous tap
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			timer_clock_tap <= `NBX_TAP_9;
		else if (is_misc && instr_word[15:8] == `NBX_OP_TMR_MEM)
		begin
			case (acc[3:2])
				2'b00: timer_clock_tap <= `NBX_TAP_9;
				2'b01: timer_clock_tap <= `NBX_TAP_3;
				2'b10: timer_clock_tap <= `NBX_TAP_15;
				default: timer_clock_tap <= timer_clock_tap;
			endcase
		end
		else if (is_misc && op7 == `NBX_OP_TMR_IMM)
		begin
			case (opnd[8:6])
				3'b000: timer_clock_tap <= `NBX_TAP_9;
				3'b001: timer_clock_tap <= `NBX_TAP_3;
				3'b010: timer_clock_tap <= `NBX_TAP_15;
				3'b100: timer_clock_tap <= `NBX_TAP_5;
				3'b101: timer_clock_tap <= `NBX_TAP_7;
				3'b110: timer_clock_tap <= `NBX_TAP_11;
				3'b111: timer_clock_tap <= `NBX_TAP_13;
				default: timer_clock_tap <= timer_clock_tap;
			endcase
		end
	end

	// debounce select; reserved patterns leave the tap alone
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			debounce_clock_tap <= `NBX_TAP_10;
		else if (is_misc && op7 == `NBX_OP_DEBOUNCE)
		begin
			case (opnd[2:0])
				3'b001: debounce_clock_tap <= `NBX_TAP_10;
				3'b010: debounce_clock_tap <= `NBX_TAP_8;
				3'b100: debounce_clock_tap <= `NBX_TAP_6;
				default: debounce_clock_tap <= debounce_clock_tap;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			backup_mode_flag <= 1'b0;
		else if (is_misc && op7 == `NBX_OP_FSET && opnd[1])
			backup_mode_flag <= 1'b1;
		else if (is_misc && op7 == `NBX_OP_FCLR && opnd[1])
			backup_mode_flag <= 1'b0;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			segments_blanked <= 1'b0;
		else if (is_misc && op7 == `NBX_OP_FSET2 && opnd[2])
			segments_blanked <= 1'b1;
		else if (is_misc && op7 == `NBX_OP_FCLR2 && opnd[2])
			segments_blanked <= 1'b0;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			timer_reload_en <= 1'b0;
		else if (is_misc && op7 == `NBX_OP_FSET2 && opnd[0])
			timer_reload_en <= 1'b1;
		else if (is_misc && op7 == `NBX_OP_FCLR2 && opnd[0])
			timer_reload_en <= 1'b0;
	end
endmodule // nbx_branch_misc_exec

// >>> nbx_exec_monitor.sv
// Purpose: port assertions for the branch and misc execution block
// Assumes: misc opcodes sit in word[15:9], results one edge after issue
// Notes: attached to every instance of the block by the bind below
`timescale 1ns/1ns
`include "nbx_defs.svh"
module nbx_exec_monitor
(
	input wire logic                     ref_clk,
	input wire logic                     reset,
	input wire logic                     instr_valid,
	input wire logic [15:0]              instr_word,
	input wire nbx_pkg::nbx_core_state_t core_state,
	input wire nbx_pkg::nbx_addr_t       program_counter,
	input wire nbx_pkg::nbx_wb_t         write_back,
	input wire logic                     carry_we,
	input wire nbx_pkg::nbx_pulse_t      pulses,
	input wire logic                     backup_mode_flag
);
	import nbx_pkg::*;
	logic        v;
	logic [15:0] w;
	logic [6:0]  m;
	logic [3:0]  a;
	assign v = instr_valid;
	assign w = instr_word;
	assign m = instr_word[15:9];
	assign a = core_state.accumulator;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_JUMP: assert property (
		v && w[15:12] == `NBX_OP_JUMP |=> program_counter == $past(w[9:0]))
		else $error("jump target not loaded");
	AST_JB: assert property (
		v && w[15:12] == `NBX_OP_BIT_BR && a[w[11:10]]
		|=> program_counter == $past(w[9:0]))
		else $error("bit branch not taken");
	AST_NONZERO_FALSE: assert property (
		v && w[15:10] == `NBX_OP_NONZERO && a == 4'h0
		|=> program_counter == $past(program_counter) + 1'b1)
		else $error("false branch did not step by one");
	AST_CARRY_BR: assert property (
		v && w[15:10] == `NBX_OP_CARRY && core_state.carry_flag
		|=> program_counter == $past(w[9:0]))
		else $error("carry branch not taken");
	AST_ADJ: assert property (
		v && w == `NBX_OP_DEC_ADJ && !core_state.carry_flag && a >= 4'h6
		|=> write_back.acc_we && write_back.data == $past(a) + 4'hA)
		else $error("adjust result wrong");
	AST_ADJ_CARRY: assert property (
		v && w[15:9] == 7'h2B |=> !carry_we)
		else $error("adjust touched carry");
	AST_CALL_RET: assert property (
		(v && w[15:12] == `NBX_OP_CALL ##1 v && w == `NBX_OP_RTS)
		|=> program_counter == $past(program_counter, 2) + 1'b1)
		else $error("return address wrong");
	AST_TMR_IMM: assert property (
		v && m == `NBX_OP_TMR_IMM
		|=> pulses.timer_start && pulses.timer_preset == $past(w[5:0]))
		else $error("immediate timer preset wrong");
	AST_PULSE_TIMER: assert property (
		v && m == `NBX_OP_PULSE && w[4]
		|=> pulses.timer_wake_clr && pulses.timer_stop)
		else $error("timer wake clear or stop missing");
	AST_PULSE_TAIL: assert property (
		v && m == `NBX_OP_PULSE && w[8] |=> pulses.prescaler_tail_clr)
		else $error("prescaler tail clear missing");
	AST_ARITH_STS: assert property (
		v && w[15:8] == `NBX_OP_ARITH_STS |=> write_back.ram_we &&
		write_back.data[3:2] == $past({core_state.carry_flag,
		core_state.zero_flag}))
		else $error("arith status nibble wrong");
	AST_SF_BACKUP: assert property (
		v && m == `NBX_OP_FSET && w[1] |=> backup_mode_flag)
		else $error("backup mode not entered");
endmodule // nbx_exec_monitor

bind nbx_branch_misc_exec nbx_exec_monitor i_nbx_exec_monitor
(
	.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid),
	.instr_word(instr_word), .core_state(core_state),
	.program_counter(program_counter), .write_back(write_back),
	.carry_we(carry_we), .pulses(pulses),
	.backup_mode_flag(backup_mode_flag)
);

// >>> nbx_branch_misc_exec_tb.sv
// Purpose: self-checking bench for the branch and misc execution block
// Assumes: one instruction per cycle, results settled by the next negedge
// Notes: misc rows check taps, levels and pulses as one packed vector
`timescale 1ns/1ns
module nbx_branch_misc_exec_tb;
	import nbx_pkg::*;
	logic            ref_clk, reset, instr_valid;
	logic [15:0]     instr_word;
	nbx_core_state_t core_state;
	nbx_addr_t       program_counter, exp_pc, p;
	nbx_wb_t         write_back;
	nbx_pulse_t      pulses;
	logic            carry_we, carry_value, backup_mode_flag;
	logic            segments_blanked, timer_reload_en;
	logic [3:0]      timer_clock_tap, debounce_clock_tap;
	logic [31:0]     obs;
	int              err_total, n_tests;
	// row: word, accumulator, 2'b0, carry, taken
	localparam logic [23:0] BR [17] = '{24'h815511, 24'h8155E0,
		24'h86AA21, 24'h88F041, 24'h88F0B0, 24'h8F0081, 24'h8F0070,
		24'h90FF51, 24'h90FF00, 24'h9BFE01, 24'h9BFE10, 24'h941231,
		24'h941232, 24'h9F4503, 24'h9F4500, 24'hA3FF01, 24'hA00003};
	// row: word, accumulator, expected vector (state carries over rows)
	localparam logic [51:0] MX [27] = '{52'hD001_0_9A00_0000,
		52'hD002_0_9800_0000, 52'hD004_0_9600_0000, 52'hD003_0_9600_0000,
		52'hD42A_0_9600_06A0, 52'hD455_0_3600_0550, 52'hD4BF_0_F600_07F0,
		52'hD4C1_0_F600_0410, 52'hD520_0_5600_0600, 52'hD54A_0_7600_04A0,
		52'hD591_0_B600_0510, 52'hD5C0_0_D600_0400, 52'h6940_7_3600_0750,
		52'h6940_B_F600_0750, 52'h6940_2_9600_0650, 52'h6940_C_9600_0450,
		52'hD601_0_9603_0000, 52'hD602_0_9640_0000, 52'hDA04_0_9660_0000,
		52'hDA01_0_9670_0000, 52'hD801_0_9672_0000, 52'hDC04_0_9650_0000,
		52'hDC01_0_9640_0000, 52'hDE01_0_9640_8000, 52'hDE08_0_9640_4000,
		52'hDE10_0_9640_3000, 52'hDF08_0_9640_4800};

	assign obs = {timer_clock_tap, debounce_clock_tap, 1'b0,
		backup_mode_flag, segments_blanked, timer_reload_en, 2'b00,
		carry_we, carry_value, pulses, 4'h0};

	nbx_branch_misc_exec i_nbx_branch_misc_exec
	(
		.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid),
		.instr_word(instr_word), .core_state(core_state),
		.program_counter(program_counter), .write_back(write_back),
		.carry_we(carry_we), .carry_value(carry_value), .pulses(pulses),
		.timer_clock_tap(timer_clock_tap),
		.debounce_clock_tap(debounce_clock_tap),
		.backup_mode_flag(backup_mode_flag),
		.segments_blanked(segments_blanked),
		.timer_reload_en(timer_reload_en)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// called at a negedge; returns at the next one with results settled
	task automatic run(input logic [15:0] w, input logic [3:0] a,
		input logic c);
		instr_word = w;
		instr_valid = 1'b1;
		core_state.accumulator = a;
		core_state.carry_flag = c;
		@(negedge ref_clk);
		exp_pc = exp_pc + 1'b1;
	endtask

	task automatic rst;
		reset = 1'b1;
		instr_valid = 1'b0;
		repeat (8) @(negedge ref_clk);
		chk(obs, 32'h9A00_0000);
		chk({write_back, program_counter}, 32'h0);
		reset = 1'b0;
		exp_pc = '0;
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	initial
	begin
		repeat (3000) @(posedge ref_clk);
		err_total++;
		end_sim();
	end

	initial
	begin
		logic [3:0] a;
		logic       c;
		err_total = 0;
		n_tests = 0;
		instr_word = 16'h0000;
		core_state = '0;
		core_state.ram_data = 4'h5;
		rst();
		foreach (BR[i])
		begin
			run(BR[i][23:8], BR[i][7:4], BR[i][1]);
			if (BR[i][0])
				exp_pc = BR[i][17:8];
			chk(program_counter, exp_pc);
		end
		$display("branch table done");
		for (int k = 0; k < 32; k++)
		begin
			a = k[3:0];
			c = k[4];
			if (c ? a > 4'h9 : a < 4'h6)
				continue;
			run(k[0] ? 16'h5740 : 16'h5600, a, c);
			chk(write_back, {1'b1, k[0], c ? a : a + 4'hA});
			chk(carry_we, 1'b0);
		end
		$display("decimal adjust done");
		foreach (MX[i])
		begin
			run(MX[i][51:36], MX[i][35:32], 1'b0);
			chk(obs, MX[i][31:0]);
			chk(program_counter, exp_pc);
		end
		$display("misc table done");
		core_state.zero_flag = 1'b0;
		core_state.start_condition_two = 1'b1;
		core_state.prescaler_stage_fifteen = 1'b1;
		run(16'h4A40, 4'h0, 1'b1);
		chk(write_back & 6'h3C, 6'h38);
		run(16'h4B40, 4'h0, 1'b1);
		chk(write_back & 6'h35, 6'h35);
		run(16'h4C40, 4'h0, 1'b1);
		chk(write_back & 6'h3C, 6'h34);
		run(16'hD802, 4'h0, 1'b0);
		chk(backup_mode_flag, 1'b0);
		$display("status reads done");
		p = exp_pc;
		run(16'hB050, 4'h0, 1'b0);
		chk(program_counter, 10'h050);
		run(16'hB3A0, 4'h0, 1'b0);
		chk(program_counter, 10'h3A0);
		run(16'hC000, 4'h0, 1'b0);
		chk(program_counter, 10'h051);
		run(16'hC000, 4'h0, 1'b0);
		chk(program_counter, p + 1'b1);
		$display("call and return done");
		rst();
		run(16'hA123, 4'h0, 1'b0);
		chk(program_counter, 10'h123);
		$display("second reset done");
		end_sim();
	end
endmodule // nbx_branch_misc_exec_tb
